// [rtl/bss_boot_select.sv]
// top of the boot source selector: samples straps, switches and fuses after reset
// assumes strap and switch inputs are static, synchronous levels (1 = pulled high / switch on)
//
// The register offsets and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/10ps
`include "bss_consts.svh"

// Function
// - both mode straps floating (high strap low, low strap high): boot from programmed fuses.
// - high strap pulled up, others floating: boot from configuration switches.
// - recovery strap low, high mode strap floating: enter usb download mode.
// - fuse override set in switch boot: use fuse settings, ignore switches.
// - low mode strap is driven from the recovery strap line inside.
// - normal boot is emmc on card port three, chosen by fuses.
module bss_boot_select
    import bss_pkg::*;
(
    // clock and reset
    input  wire logic                clk_i,
    input  wire logic                reset_i,
    // straps and switches
    input  wire logic                boot_strap_high_i,
    input  wire logic                recovery_strap_n_i,
    input  wire logic [7:0]          slider_switch_i,
    // fuses
    input  wire logic                fuse_boot_override_i,
    input  wire logic [1:0]          fuse_boot_src_i,
    // avalon-mm
    input  wire logic [3:0]          avs_address_i,
    input  wire logic                avs_read_i,
    input  wire logic                avs_write_i,
    input  wire logic [31:0]         avs_writedata_i,
    input  wire logic [3:0]          avs_byteenable_i,
    output logic      [31:0]         avs_readdata_o,
    output logic                     avs_waitrequest_o,
    // decoded result
    output bss_pkg::bss_mode_t       boot_mode_o,
    output bss_pkg::bss_src_t        boot_src_o,
    output logic                     boot_strap_low_o,
    output logic                     boot_valid_o
);
    import bss_pkg::*;

    // *****************************************************************
    // internal wiring of the low strap
    // *****************************************************************
    logic boot_strap_low;
    assign boot_strap_low   = recovery_strap_n_i;
    assign boot_strap_low_o = boot_strap_low;

    // *****************************************************************
    // decode functions
    // *****************************************************************
    function automatic bss_src_t switch_src(input logic [7:0] sw);
        bss_src_t s;
        s = BSS_SRC_NONE;
        if (sw == `BSS_SW_EMMC) begin
            s = BSS_SRC_EMMC;
        end else if (sw == `BSS_SW_QSPI) begin
            s = BSS_SRC_QSPI;
        end else if (sw == `BSS_SW_SD1) begin
            s = BSS_SRC_SD1;
        end
        return s;
    endfunction : switch_src

    function automatic bss_src_t fuse_src(input logic [1:0] f);
        bss_src_t s;
        s = BSS_SRC_NONE;
        unique case (f)
            `BSS_FUSE_SRC_EMMC: s = BSS_SRC_EMMC;
            `BSS_FUSE_SRC_QSPI: s = BSS_SRC_QSPI;
            `BSS_FUSE_SRC_SD1:  s = BSS_SRC_SD1;
            `BSS_FUSE_SRC_NONE: s = BSS_SRC_NONE;
        endcase
        return s;
    endfunction : fuse_src

    // *****************************************************************
    // combinational decode of the live levels
    // *****************************************************************
    bss_mode_t next_mode;
    bss_src_t  next_src;

    // the strap pair is {recovery line, high strap}; every code is decoded,
    // so a floating level modelled either way still yields a defined mode
    always_comb begin
        next_mode = BSS_MODE_BAD;
        next_src  = BSS_SRC_NONE;
        unique case ({recovery_strap_n_i, boot_strap_high_i})
            2'b00: begin
                next_mode = BSS_MODE_USB;
                next_src  = BSS_SRC_USB;
            end
            2'b11: begin
                next_mode = BSS_MODE_STRAP;
                next_src  = fuse_boot_override_i ? fuse_src(fuse_boot_src_i)
                                                 : switch_src(slider_switch_i);
            end
            2'b10: begin
                next_mode = BSS_MODE_FUSE;
                next_src  = fuse_src(fuse_boot_src_i);
            end
            2'b01: begin
                // high strap fitted with the recovery jumper in: pick no source
                next_mode = BSS_MODE_BAD;
                next_src  = BSS_SRC_NONE;
            end
        endcase
    end

    // *****************************************************************
    // sampling sequence
    // *****************************************************************
    bss_state_t state;
    bss_state_t next_state;
    logic       relatch;
    logic       sample_now;

    always_comb begin
        next_state = BSS_ST_RESET;
        unique case (state)
            BSS_ST_RESET:  next_state = BSS_ST_SAMPLE;
            BSS_ST_SAMPLE: next_state = BSS_ST_HOLD;
            BSS_ST_HOLD:   next_state = relatch ? BSS_ST_SAMPLE : BSS_ST_HOLD;
            default:       next_state = BSS_ST_RESET;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state <= BSS_ST_RESET;
        end else begin
            state <= next_state;
        end
    end

    // the only cycle in which the live levels are taken; one idle state after
    // release lets the carrier levels settle before they are used
    assign sample_now = (state == BSS_ST_SAMPLE);

    // *****************************************************************
    // captured result
    // *****************************************************************
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            boot_mode_o  <= BSS_MODE_FUSE;
            boot_src_o   <= BSS_SRC_NONE;
            boot_valid_o <= 1'b0;
        end else if (sample_now) begin
            boot_mode_o  <= next_mode;
            boot_src_o   <= next_src;
            boot_valid_o <= 1'b1;
        end
    end

    // raw levels seen at the same sample, kept for software
    logic [7:0] switch_seen;
    logic       override_seen;
    logic       high_seen;
    logic       recovery_seen;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            switch_seen   <= 8'h00;
            override_seen <= 1'b0;
            high_seen     <= 1'b0;
            recovery_seen <= 1'b1;
        end else if (sample_now) begin
            switch_seen   <= slider_switch_i;
            override_seen <= fuse_boot_override_i;
            high_seen     <= boot_strap_high_i;
            recovery_seen <= recovery_strap_n_i;
        end
    end

    // *****************************************************************
    // register words
    // *****************************************************************
    logic [31:0] status_word;
    logic [31:0] switch_word;

    // status fields by position, unused bits read as zero
    always_comb begin
        status_word                          = 32'h0000_0000;
        status_word[`BSS_STAT_MODE_LSB +: 2] = boot_mode_o;
        status_word[`BSS_STAT_SRC_LSB +: 3]  = boot_src_o;
        status_word[`BSS_STAT_VALID]         = boot_valid_o;
        status_word[`BSS_STAT_OVERRIDE]      = override_seen;
        status_word[`BSS_STAT_HIGH]          = high_seen;
        status_word[`BSS_STAT_RECOVERY]      = recovery_seen;
    end

    assign switch_word = {24'h00_0000, switch_seen};

    // *****************************************************************
    // register slave
    // *****************************************************************

    bss_avalon_slave u_slave (
        .clk_i             (clk_i),
        .reset_i           (reset_i),
        .avs_address_i     (avs_address_i),
        .avs_read_i        (avs_read_i),
        .avs_write_i       (avs_write_i),
        .avs_writedata_i   (avs_writedata_i),
        .avs_byteenable_i  (avs_byteenable_i),
        .avs_readdata_o    (avs_readdata_o),
        .avs_waitrequest_o (avs_waitrequest_o),
        .status_word_i     (status_word),
        .switch_word_i     (switch_word),
        .relatch_o         (relatch)
    );

endmodule : bss_boot_select

// [rtl/bss_consts.svh]
// constants for the boot source selector: switch patterns, fuse encodings, register map
// assumes inclusion by the rtl modules and the bench side
`ifndef BSS_CONSTS_SVH
`define BSS_CONSTS_SVH

// *****************************************************************
// switch patterns, bit 0 is switch 1
// *****************************************************************
`define BSS_SW_EMMC        8'h4A
`define BSS_SW_QSPI        8'h01
`define BSS_SW_SD1         8'h84

// *****************************************************************
// fuse source field encodings
// *****************************************************************
`define BSS_FUSE_SRC_EMMC  2'h0
`define BSS_FUSE_SRC_QSPI  2'h1
`define BSS_FUSE_SRC_SD1   2'h2
`define BSS_FUSE_SRC_NONE  2'h3

// *****************************************************************
// register map
// *****************************************************************
`define BSS_REG_STATUS     4'h0
`define BSS_REG_SWITCH     4'h4
`define BSS_REG_CTRL       4'h8
`define BSS_CTRL_RESET     1'b0

// *****************************************************************
// status word field positions
// *****************************************************************
`define BSS_STAT_MODE_LSB  0
`define BSS_STAT_SRC_LSB   2
`define BSS_STAT_VALID     5
`define BSS_STAT_OVERRIDE  6
`define BSS_STAT_HIGH      7
`define BSS_STAT_RECOVERY  8

`endif

// [rtl/bss_pkg.sv]
// types shared by the boot source selector
// assumes bss_consts.svh on the include path
package bss_pkg;

    // *****************************************************************
    // decoded boot mode
    // *****************************************************************
    typedef enum logic [1:0] {
        BSS_MODE_FUSE   = 2'b00,
        BSS_MODE_STRAP  = 2'b01,
        BSS_MODE_USB    = 2'b10,
        BSS_MODE_BAD    = 2'b11
    } bss_mode_t;

    // *****************************************************************
    // decoded boot source
    // *****************************************************************
    typedef enum logic [2:0] {
        BSS_SRC_EMMC  = 3'b000,
        BSS_SRC_QSPI  = 3'b001,
        BSS_SRC_SD1   = 3'b010,
        BSS_SRC_USB   = 3'b011,
        BSS_SRC_NONE  = 3'b100
    } bss_src_t;

    // *****************************************************************
    // sampling sequence
    // *****************************************************************
    typedef enum logic [2:0] {
        BSS_ST_RESET  = 3'b001,
        BSS_ST_SAMPLE = 3'b010,
        BSS_ST_HOLD   = 3'b100
    } bss_state_t;

endpackage : bss_pkg

// [rtl/bss_avalon_slave.sv]
// avalon-mm register slave for the boot source selector
// assumes a master that holds its request until waitrequest is seen low
`timescale 1ns/10ps
`include "bss_consts.svh"

module bss_avalon_slave (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    // avalon-mm
    input  wire logic [3:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    // register contents
    input  wire logic [31:0] status_word_i,
    input  wire logic [31:0] switch_word_i,
    output logic             relatch_o
);
    // *****************************************************************
    // one wait state on every access, answer in the second cycle
    // *****************************************************************
    logic done;

    always_ff @(posedge clk_i) begin
        if (reset_i || done) begin
            done <= 1'b0;
        end else begin
            done <= avs_read_i | avs_write_i;
        end
    end

    assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~done;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            avs_readdata_o <= 32'h0000_0000;
        end else if (avs_read_i && !done) begin
            unique case (avs_address_i)
                `BSS_REG_STATUS: avs_readdata_o <= status_word_i;
                `BSS_REG_SWITCH: avs_readdata_o <= switch_word_i;
                default:         avs_readdata_o <= 32'h0000_0000;
            endcase
        end
    end

    // writing 1 to ctrl bit 0 requests a fresh sample of the straps
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            relatch_o <= `BSS_CTRL_RESET;
        end else begin
            relatch_o <= avs_write_i && done && avs_address_i == `BSS_REG_CTRL
                         && avs_byteenable_i[0] && avs_writedata_i[0];
        end
    end

endmodule : bss_avalon_slave

// [testbench/bss_carrier_model.sv]
// carrier board model: mode straps, recovery jumper, slider switches
// assumes the bench picks the fitted straps through setting_i
`timescale 1ns/10ps
module bss_carrier_model (
    // strap fit: bit0 high strap pull-up, bit1 recovery jumper
    input  wire logic [1:0] setting_i,
    input  wire logic [7:0] switches_i,
    // pins towards the module
    output logic            boot_strap_high_o,
    output logic            recovery_strap_n_o,
    output logic [7:0]      slider_switch_o
);
    // an unfitted high strap reads low, as with the optional pull-down
    assign boot_strap_high_o  = setting_i[0];
    // the jumper pulls the recovery line low, left floating it reads high
    assign recovery_strap_n_o = !setting_i[1];
    assign slider_switch_o    = switches_i;
endmodule : bss_carrier_model

// [testbench/bss_boot_select_properties.sv]
// assertions on the boot source selector ports
// assumes bss_pkg compiled first and straps static around reset release
`timescale 1ns/10ps
`include "bss_consts.svh"
module bss_sel_properties
    import bss_pkg::*;
(
    // clock, reset, straps, fuses
    input wire logic               clk_i,
    input wire logic               reset_i,
    input wire logic               boot_strap_high_i,
    input wire logic               recovery_strap_n_i,
    input wire logic [7:0]         slider_switch_i,
    input wire logic               fuse_boot_override_i,
    input wire logic [1:0]         fuse_boot_src_i,
    // decoded result
    input wire bss_pkg::bss_mode_t boot_mode_o,
    input wire bss_pkg::bss_src_t  boot_src_o,
    input wire logic               boot_strap_low_o,
    input wire logic               boot_valid_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);
    function automatic bss_src_t f_src(logic [1:0] f);
        return (f == `BSS_FUSE_SRC_NONE) ? BSS_SRC_NONE : bss_src_t'({1'b0, f});
    endfunction : f_src
    function automatic bss_src_t s_src(logic [7:0] s);
        return (s == `BSS_SW_EMMC) ? BSS_SRC_EMMC : (s == `BSS_SW_QSPI) ? BSS_SRC_QSPI :
            (s == `BSS_SW_SD1) ? BSS_SRC_SD1 : BSS_SRC_NONE;
    endfunction : s_src
    // release with given strap levels, held through the sampling edge
    sequence s_boot(logic h, logic r);
        $fell(reset_i) && boot_strap_high_i == h && recovery_strap_n_i == r
            ##1 $stable(boot_strap_high_i) && $stable(recovery_strap_n_i);
    endsequence
    a_low_strap: assert property (boot_strap_low_o == recovery_strap_n_i)
        else $error("low strap not following recovery line");
    a_valid_time: assert property ($fell(reset_i) |-> !boot_valid_o ##1 !boot_valid_o ##1 boot_valid_o)
        else $error("valid not two edges after release");
    a_fuse_boot: assert property (s_boot(1'b0, 1'b1) |=> boot_mode_o == BSS_MODE_FUSE && boot_src_o == f_src(fuse_boot_src_i))
        else $error("fuse boot wrong");
    a_strap_boot: assert property (s_boot(1'b1, 1'b1) ##0 !fuse_boot_override_i |=>
        boot_mode_o == BSS_MODE_STRAP && boot_src_o == s_src(slider_switch_i))
        else $error("strap boot wrong");
    a_fuse_override: assert property (s_boot(1'b1, 1'b1) ##0 fuse_boot_override_i |=> boot_src_o == f_src(fuse_boot_src_i))
        else $error("override ignored");
    a_usb_boot: assert property (s_boot(1'b0, 1'b0) |=> boot_mode_o == BSS_MODE_USB && boot_src_o == BSS_SRC_USB)
        else $error("usb boot wrong");
    a_bad_combo: assert property (s_boot(1'b1, 1'b0) |=> boot_mode_o == BSS_MODE_BAD && boot_src_o == BSS_SRC_NONE)
        else $error("illegal strap combination accepted");
    a_result_hold: assert property ($rose(boot_valid_o) |=> ($stable(boot_mode_o) && $stable(boot_src_o)) [*2])
        else $error("result not held");
endmodule : bss_sel_properties
bind bss_boot_select bss_sel_properties u_props (.clk_i(clk_i), .reset_i(reset_i),
    .boot_strap_high_i(boot_strap_high_i), .recovery_strap_n_i(recovery_strap_n_i), .slider_switch_i(slider_switch_i),
    .fuse_boot_override_i(fuse_boot_override_i), .fuse_boot_src_i(fuse_boot_src_i), .boot_mode_o(boot_mode_o),
    .boot_src_o(boot_src_o), .boot_strap_low_o(boot_strap_low_o), .boot_valid_o(boot_valid_o));

// [testbench/testbench.sv]
// self-checking bench for the boot source selector
// assumes the carrier model drives straps and switches; bench drives fuses and bus
`timescale 1ns/10ps
`include "bss_consts.svh"
module testbench;
    import bss_pkg::*;
    logic        clk_i    = 1'b0;
    logic        reset_i  = 1'b1;
    logic [1:0]  setting  = 2'h0;
    logic [7:0]  switches = 8'h00;
    logic        f_ovr    = 1'b0;
    logic [1:0]  f_src    = 2'h0;
    logic [3:0]  addr     = 4'h0;
    logic        rd       = 1'b0;
    logic        wr       = 1'b0;
    logic [31:0] wdata    = 32'h0000_0000;
    logic [31:0] rdata;
    logic [31:0] q;
    logic [7:0]  slider;
    logic        wait_req, strap_hi, rec_n, strap_lo, valid;
    bss_mode_t   mode;
    bss_src_t    src;
    int          n_mismatch = 0;
    int          n_checks   = 0;
    always #5 clk_i = ~clk_i;
    bss_carrier_model carrier (.setting_i(setting), .switches_i(switches), .boot_strap_high_o(strap_hi),
        .recovery_strap_n_o(rec_n), .slider_switch_o(slider));
    bss_boot_select dut (.clk_i(clk_i), .reset_i(reset_i), .boot_strap_high_i(strap_hi),
        .recovery_strap_n_i(rec_n), .slider_switch_i(slider), .fuse_boot_override_i(f_ovr),
        .fuse_boot_src_i(f_src), .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
        .avs_writedata_i(wdata), .avs_byteenable_i(4'hF), .avs_readdata_o(rdata),
        .avs_waitrequest_o(wait_req), .boot_mode_o(mode), .boot_src_o(src),
        .boot_strap_low_o(strap_lo), .boot_valid_o(valid));
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : print_verdict
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        logic done;
        done = 1'b0;
        @(posedge clk_i);
        addr  <= a;
        wdata <= d;
        wr    <= w;
        rd    <= !w;
        // hold the request until waitrequest is seen low at a rising edge
        for (int i = 0; i < 20 && !done; i++) begin
            @(posedge clk_i);
            if (wait_req === 1'b0) begin
                done = 1'b1;
                q    = rdata;
            end
        end
        rd <= 1'b0;
        wr <= 1'b0;
        if (!done) begin
            n_mismatch++;
            print_verdict();
        end
    endtask : bus
    task automatic boot(input logic [1:0] s, input logic [7:0] sw, input logic o, input logic [1:0] f);
        @(posedge clk_i);
        reset_i  <= 1'b1;
        setting  <= s;
        switches <= sw;
        f_ovr    <= o;
        f_src    <= f;
        repeat (4) @(posedge clk_i);
        reset_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        @(negedge clk_i);
        chk("valid", 32'h1, valid);
    endtask : boot
    task automatic test_fuse;
        bss_src_t exp [4] = '{BSS_SRC_EMMC, BSS_SRC_QSPI, BSS_SRC_SD1, BSS_SRC_NONE};
        for (int i = 0; i < 4; i++) begin
            boot(2'h0, `BSS_SW_QSPI, 1'b0, 2'(i));
            chk("fuse mode", BSS_MODE_FUSE, mode);
            chk("fuse source", exp[i], src);
        end
        $display("test_fuse done");
    endtask : test_fuse
    task automatic test_strap;
        logic [7:0] pat [4] = '{`BSS_SW_EMMC, `BSS_SW_QSPI, `BSS_SW_SD1, 8'h4B};
        bss_src_t   exp [4] = '{BSS_SRC_EMMC, BSS_SRC_QSPI, BSS_SRC_SD1, BSS_SRC_NONE};
        for (int i = 0; i < 4; i++) begin
            boot(2'h1, pat[i], 1'b0, 2'h3);
            chk("strap mode", BSS_MODE_STRAP, mode);
            chk("switch source", exp[i], src);
        end
        boot(2'h1, `BSS_SW_QSPI, 1'b1, 2'h2);
        chk("override source", BSS_SRC_SD1, src);
        $display("test_strap done");
    endtask : test_strap
    task automatic test_usb;
        boot(2'h2, `BSS_SW_EMMC, 1'b0, 2'h0);
        chk("usb mode", BSS_MODE_USB, mode);
        chk("usb source", BSS_SRC_USB, src);
        chk("low strap", 32'h0, strap_lo);
        boot(2'h3, `BSS_SW_EMMC, 1'b0, 2'h0);
        chk("bad mode", BSS_MODE_BAD, mode);
        chk("bad source", BSS_SRC_NONE, src);
        $display("test_usb done");
    endtask : test_usb
    task automatic test_hold;
        boot(2'h1, `BSS_SW_EMMC, 1'b0, 2'h1);
        @(posedge clk_i);
        setting  <= 2'h0;
        switches <= `BSS_SW_QSPI;
        repeat (5) @(posedge clk_i);
        @(negedge clk_i);
        chk("held mode", BSS_MODE_STRAP, mode);
        chk("held source", BSS_SRC_EMMC, src);
        bus(1'b0, `BSS_REG_STATUS, 32'h0000_0000);
        chk("status", {23'h0, 1'b1, 1'b1, 1'b0, 1'b1, BSS_SRC_EMMC, BSS_MODE_STRAP}, q);
        bus(1'b0, `BSS_REG_SWITCH, 32'h0000_0000);
        chk("switch word", {24'h0, `BSS_SW_EMMC}, q);
        bus(1'b0, 4'hC, 32'h0000_0000);
        chk("unmapped", 32'h0, q);
        bus(1'b1, `BSS_REG_CTRL, 32'h0000_0001);
        repeat (6) @(posedge clk_i);
        @(negedge clk_i);
        chk("resampled mode", BSS_MODE_FUSE, mode);
        chk("resampled source", BSS_SRC_QSPI, src);
        $display("test_hold done");
    endtask : test_hold
    initial begin
        test_fuse();
        test_strap();
        test_usb();
        test_hold();
        print_verdict();
    end
endmodule : testbench
